/* sea_map.vh */
// register map, field positions, reset values and timing for the eeprom port
`ifndef SEA_MAP_VH
`define SEA_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SEA_OFS_MSC 12'h0b0
`define SEA_OFS_EAC 12'h0b4
`define SEA_OFS_IST 12'h0c0
`define SEA_OFS_IEN 12'h0c4
`define SEA_OFS_ICL 12'h0c8

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SEA_MSC_PRESC_HI 15
`define SEA_MSC_MODE_LO 20
`define SEA_MSC_MODE_HI 21
`define SEA_EAC_ADDR_HI 15
`define SEA_EAC_DATA_LO 16
`define SEA_EAC_DATA_HI 23
`define SEA_EAC_BUSY 24
`define SEA_EAC_DONE 25
`define SEA_EAC_OP 26
`define SEA_IRQ_DONE 0
`define SEA_IRQ_NACK 1

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define SEA_PRESC_RST 16'h0053
`define SEA_MODE_RST 2'h0
`define SEA_MODE_NORMAL 2'h0
`define SEA_MODE_FAST 2'h1
`define SEA_MODE_OFF 2'h2
`define SEA_OP_WRITE 1'b0
`define SEA_OP_READ 1'b1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SEA_CLK_PERIOD_NS 8
`define SEA_PRESC_UNIT_NS 32
`define SEA_FILT_NORMAL_NS 1000
`define SEA_FILT_FAST_NS 100
`define SEA_FILT_NORMAL_CYC (`SEA_FILT_NORMAL_NS / `SEA_CLK_PERIOD_NS)
`define SEA_FILT_FAST_CYC (`SEA_FILT_FAST_NS / `SEA_CLK_PERIOD_NS)

`endif

/* sea_glitch_filter.v */
// glitch counter for one serial line, with optional pin synchroniser
`default_nettype none
`include "sea_map.vh"

module sea_glitch_filter #(
  parameter SYNC = 1
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [1:0] mode,
  input wire line_in,
  output reg line_out
);

  // ------------------------------------------------------------
  // synchroniser: a change counts once stages two and three agree
  // ------------------------------------------------------------
  reg s1_q; // first stage, read only by s2_q
  reg s2_q; // second stage
  reg s3_q; // third stage
  reg stable_q; // last agreed level
  reg [6:0] cnt_q; // cycles the new level has stood
  wire level; // level the counter looks at
  reg [6:0] limit; // delay chosen by the mode
  localparam [31:0] LIM_FAST = `SEA_FILT_FAST_CYC; // fast cycles
  localparam [31:0] LIM_NORM = `SEA_FILT_NORMAL_CYC; // normal cycles

  // three flops on the raw line
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      stable_q <= 1'b1;
    end else begin
      s1_q <= line_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        stable_q <= s3_q;
      end
    end
  end

  assign level = (SYNC != 0) ? stable_q : line_in;

  // delay length per mode; reserved code behaves as normal
  always @* begin
    case (mode)
      `SEA_MODE_FAST: limit = LIM_FAST[6:0];
      `SEA_MODE_OFF: limit = 7'h00;
      default: limit = LIM_NORM[6:0];
    endcase
  end

  // ------------------------------------------------------------
  // counter: new level passes after standing for limit + 1 cycles
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 7'h00;
      line_out <= 1'b1;
    end else if (level == line_out) begin
      cnt_q <= 7'h00;
    end else if (cnt_q >= limit) begin
      cnt_q <= 7'h00;
      line_out <= level;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

endmodule // sea_glitch_filter
`default_nettype wire

/* sea_clk_div.v */
// half-period tick generator for the serial clock prescaler
`default_nettype none
`include "sea_map.vh"

module sea_clk_div (
  input wire sys_clk,
  input wire rst_b,
  input wire [15:0] presc,
  input wire hold,
  output reg tick
);

  // ------------------------------------------------------------
  // half period in core cycles: presc * 32 ns / 2 at 8 ns
  // ------------------------------------------------------------
  wire [31:0] half_full; // exact quotient, 32 bits
  wire [17:0] half; // cycles per half period
  wire stopped; // prescaler value of zero or one
  reg [17:0] cnt_q; // cycles spent in this half

  assign half_full = ({16'h0000, presc} * `SEA_PRESC_UNIT_NS) /
                     (2 * `SEA_CLK_PERIOD_NS);
  assign half = half_full[17:0];
  assign stopped = (presc < 16'h0002);

  // each phase lasts a full half period, restarted by hold
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 18'h00000;
      tick <= 1'b0;
    end else if (hold || stopped) begin
      cnt_q <= 18'h00000;
      tick <= 1'b0;
    end else if (cnt_q + 18'h00001 >= half) begin
      cnt_q <= 18'h00000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 18'h00001;
      tick <= 1'b0;
    end
  end

endmodule // sea_clk_div
`default_nettype wire

/* sea_top.v */
// serial eeprom access port: registers and master serial engine
//
// Notes on behaviour
// - mode 0 delays lines about 1 us
// - mode 1 delays lines 100 ns
// - mode 2 no delay; 3 reserved
// - clock period 32 ns times prescaler; 0,1 stop
// - clock low at least half a period
// - prescaler 0x53 meets low time minimum
// - eeprom address from bits 15 to 0
// - data field write starts one operation
// - write stores the written data byte
// - read loads data field with eeprom byte
// - busy bit 24 set while operating
// - done bit 25 set at end, write-one clears
// - operation select bit 26: 0 write, 1 read
`default_nettype none
`include "sea_map.vh"

module sea_top #(
  parameter [6:0] EEPROM_DEV = 7'h50
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output wire irq,
  input wire master_serial_clock_pin_i,
  output wire master_serial_clock_pin_o,
  output wire master_serial_clock_pin_oe_b,
  input wire master_serial_data_pin_i,
  output wire master_serial_data_pin_o,
  output wire master_serial_data_pin_oe_b
);

  // ------------------------------------------------------------
  // engine states
  // ------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_START = 4'h1;
  localparam [3:0] ST_BIT_LO = 4'h2;
  localparam [3:0] ST_BIT_HI = 4'h3;
  localparam [3:0] ST_RS_LO = 4'h4;
  localparam [3:0] ST_RS_HI = 4'h5;
  localparam [3:0] ST_STOP_LO = 4'h6;
  localparam [3:0] ST_STOP_HI = 4'h7;
  localparam [3:0] ST_STOP_END = 4'h8;

  // byte steps of one access
  localparam [2:0] STEP_DEVW = 3'h0;
  localparam [2:0] STEP_AHI = 3'h1;
  localparam [2:0] STEP_ALO = 3'h2;
  localparam [2:0] STEP_THIRD = 3'h3;
  localparam [2:0] STEP_RDATA = 3'h4;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [15:0] presc_q; // master_clock_prescaler
  reg [1:0] mode_q; // master_glitch_filter_mode
  reg [15:0] addr_q; // eeprom byte address
  reg [7:0] data_q; // data field
  reg busy_q; // operation in progress
  reg done_q; // operation completed
  reg op_q; // operation_select
  reg [1:0] ist_q; // sticky interrupt status
  reg [1:0] ien_q; // interrupt enables

  // engine state
  reg [3:0] state_q; // engine state
  reg [2:0] step_q; // current byte step
  reg [3:0] bit_q; // bit within byte, 8 is ack
  reg [7:0] shift_q; // transmit / receive shifter
  reg ev_done; // one-cycle completion event
  reg ev_nack; // one-cycle no-acknowledge event

  // decoded bus accesses
  wire wr_msc; // write to master_serial_control
  wire wr_eac; // write to eeprom_access_control
  wire wr_ien; // write to interrupt enable
  wire wr_icl; // write to interrupt clear
  wire start_req; // accepted start

  // line signals
  wire scl_f; // filtered clock line
  wire sda_f; // filtered data line
  reg scl_rel; // engine releases the clock line
  reg sda_rel; // engine releases the data line
  wire scl_rel_f; // delayed clock release
  wire sda_rel_f; // delayed data release
  wire tick; // half period elapsed
  wire hold; // hold prescaler counter at zero

  // ------------------------------------------------------------
  // byte to send at a given step
  // ------------------------------------------------------------
  function [7:0] sea_tx_byte;
    input [2:0] step;
    input [15:0] addr;
    input [7:0] data;
    input op;
    begin
      case (step)
        STEP_DEVW: sea_tx_byte = {EEPROM_DEV, 1'b0};
        STEP_AHI: sea_tx_byte = addr[15:8];
        STEP_ALO: sea_tx_byte = addr[7:0];
        STEP_THIRD: begin
          if (op == `SEA_OP_READ) begin
            sea_tx_byte = {EEPROM_DEV, 1'b1};
          end else begin
            sea_tx_byte = data;
          end
        end
        default: sea_tx_byte = 8'hff; // released while reading
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  assign wr_msc = reg_wr && (reg_addr == `SEA_OFS_MSC);
  assign wr_eac = reg_wr && (reg_addr == `SEA_OFS_EAC);
  assign wr_ien = reg_wr && (reg_addr == `SEA_OFS_IEN);
  assign wr_icl = reg_wr && (reg_addr == `SEA_OFS_ICL);
  assign start_req = wr_eac && !busy_q;

  // ------------------------------------------------------------
  // control register writes
  // ------------------------------------------------------------
  // prescaler and filter mode; 0x53 default meets low time
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_q <= `SEA_PRESC_RST;
      mode_q <= `SEA_MODE_RST;
    end else if (wr_msc) begin
      presc_q <= reg_wdata[`SEA_MSC_PRESC_HI:0];
      mode_q <= reg_wdata[`SEA_MSC_MODE_HI:`SEA_MSC_MODE_LO];
    end
  end

  // address and op are held steady while busy
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 16'h0000;
      op_q <= `SEA_OP_WRITE;
    end else if (start_req) begin
      addr_q <= reg_wdata[`SEA_EAC_ADDR_HI:0];
      op_q <= reg_wdata[`SEA_EAC_OP];
    end
  end

  // data field: written byte for writes, eeprom byte for reads
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= 8'h00;
    end else if (start_req &&
                 reg_wdata[`SEA_EAC_OP] == `SEA_OP_WRITE) begin
      data_q <= reg_wdata[`SEA_EAC_DATA_HI:`SEA_EAC_DATA_LO];
    end else if (state_q == ST_BIT_HI && tick && scl_f &&
                 step_q == STEP_RDATA && bit_q == 4'h8) begin
      data_q <= shift_q;
    end
  end

  // busy and done flags; completion wins over a clear
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (start_req) begin
        busy_q <= 1'b1;
      end else if (ev_done) begin
        busy_q <= 1'b0;
      end
      if (ev_done) begin
        done_q <= 1'b1;
      end else if (start_req) begin
        done_q <= 1'b0;
      end else if (wr_eac && reg_wdata[`SEA_EAC_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt status, enable and clear
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ist_q <= 2'h0;
      ien_q <= 2'h0;
    end else begin
      if (wr_ien) begin
        ien_q <= reg_wdata[1:0];
      end
      // a new event beats a clear in the same cycle
      ist_q <= (ist_q & ~(wr_icl ? reg_wdata[1:0] : 2'h0)) |
               {ev_nack, ev_done};
    end
  end

  assign irq = |(ist_q & ien_q);

  // ------------------------------------------------------------
  // read data, valid only in the cycle after the strobe
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SEA_OFS_MSC: reg_rdata <= {10'h000, mode_q, 4'h0, presc_q};
        `SEA_OFS_EAC: reg_rdata <= {5'h00, op_q, done_q, busy_q,
                                    data_q, addr_q};
        `SEA_OFS_IST: reg_rdata <= {30'h00000000, ist_q};
        `SEA_OFS_IEN: reg_rdata <= {30'h00000000, ien_q};
        default: reg_rdata <= 32'h00000000; // unmapped, clear reg
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // line drive from state: released means high
  // ------------------------------------------------------------
  always @* begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    case (state_q)
      ST_START: sda_rel = 1'b0;
      ST_BIT_LO: begin
        scl_rel = 1'b0;
        sda_rel = (bit_q < 4'h8) ? shift_q[7] : 1'b1;
      end
      ST_BIT_HI: sda_rel = (bit_q < 4'h8) ? shift_q[7] : 1'b1;
      ST_RS_LO: scl_rel = 1'b0;
      ST_STOP_LO: begin
        scl_rel = 1'b0;
        sda_rel = 1'b0;
      end
      ST_STOP_HI: sda_rel = 1'b0;
      default: begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
      end
    endcase
  end

  // hold the half-period count while idle or the clock is stretched
  assign hold = (state_q == ST_IDLE) || (scl_rel && !scl_f);

  // ------------------------------------------------------------
  // engine sequencer
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      step_q <= STEP_DEVW;
      bit_q <= 4'h0;
      shift_q <= 8'hff;
      ev_done <= 1'b0;
      ev_nack <= 1'b0;
    end else begin
      ev_done <= 1'b0;
      ev_nack <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            state_q <= ST_START;
            step_q <= STEP_DEVW;
          end
        end
        ST_START: begin
          if (tick) begin
            state_q <= ST_BIT_LO;
            bit_q <= 4'h0;
            shift_q <= sea_tx_byte(step_q, addr_q, data_q, op_q);
          end
        end
        ST_BIT_LO: begin
          if (tick) begin
            state_q <= ST_BIT_HI;
          end
        end
        ST_BIT_HI: begin
          if (tick && scl_f) begin
            if (bit_q < 4'h8) begin
              // sample and shift one data bit
              shift_q <= {shift_q[6:0], sda_f};
              bit_q <= bit_q + 4'h1;
              state_q <= ST_BIT_LO;
            end else if (step_q != STEP_RDATA && sda_f) begin
              // eeprom refused the byte: abort
              ev_nack <= 1'b1;
              state_q <= ST_STOP_LO;
            end else begin
              case (step_q)
                STEP_ALO: begin
                  step_q <= STEP_THIRD;
                  state_q <= (op_q == `SEA_OP_READ) ? ST_RS_LO
                                                    : ST_BIT_LO;
                  bit_q <= 4'h0;
                  shift_q <= sea_tx_byte(STEP_THIRD, addr_q, data_q,
                                         op_q);
                end
                STEP_THIRD: begin
                  if (op_q == `SEA_OP_READ) begin
                    step_q <= STEP_RDATA;
                    state_q <= ST_BIT_LO;
                    bit_q <= 4'h0;
                    shift_q <= 8'hff;
                  end else begin
                    state_q <= ST_STOP_LO;
                  end
                end
                STEP_RDATA: state_q <= ST_STOP_LO;
                default: begin
                  step_q <= step_q + 3'h1;
                  state_q <= ST_BIT_LO;
                  bit_q <= 4'h0;
                  shift_q <= sea_tx_byte(step_q + 3'h1, addr_q, data_q,
                                         op_q);
                end
              endcase
            end
          end
        end
        ST_RS_LO: begin
          if (tick) begin
            state_q <= ST_RS_HI;
          end
        end
        ST_RS_HI: begin
          if (tick && scl_f) begin
            state_q <= ST_START; // repeated start for the read
          end
        end
        ST_STOP_LO: begin
          if (tick) begin
            state_q <= ST_STOP_HI;
          end
        end
        ST_STOP_HI: begin
          if (tick && scl_f) begin
            state_q <= ST_STOP_END;
          end
        end
        ST_STOP_END: begin
          if (tick) begin
            state_q <= ST_IDLE;
            ev_done <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // prescaler and glitch counters
  // ------------------------------------------------------------
  sea_clk_div u_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .presc(presc_q),
    .hold(hold),
    .tick(tick)
  );

  // sampling path through the glitch counters
  sea_glitch_filter #(.SYNC(1)) u_scl_in (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mode(mode_q),
    .line_in(master_serial_clock_pin_i),
    .line_out(scl_f)
  );

  sea_glitch_filter #(.SYNC(1)) u_sda_in (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mode(mode_q),
    .line_in(master_serial_data_pin_i),
    .line_out(sda_f)
  );

  // driving path delayed by the same counters
  sea_glitch_filter #(.SYNC(0)) u_scl_out (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mode(mode_q),
    .line_in(scl_rel),
    .line_out(scl_rel_f)
  );

  sea_glitch_filter #(.SYNC(0)) u_sda_out (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mode(mode_q),
    .line_in(sda_rel),
    .line_out(sda_rel_f)
  );

  // open drain: drive low, enable low while driving
  assign master_serial_clock_pin_o = 1'b0;
  assign master_serial_clock_pin_oe_b = scl_rel_f;
  assign master_serial_data_pin_o = 1'b0;
  assign master_serial_data_pin_oe_b = sda_rel_f;

endmodule // sea_top
`default_nettype wire

/* sea_checker.sv */
// assertion checker for the serial eeprom access port
`default_nettype none
`include "sea_map.vh"
module sea_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic master_serial_clock_pin_oe_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic ck = master_serial_clock_pin_oe_b; // high while clock released
  wire logic eac_wr = reg_wr && reg_addr == `SEA_OFS_EAC; // start request
  wire logic eac_rd = reg_rd && reg_addr == `SEA_OFS_EAC; // access read
  wire logic msc_rd = reg_rd && reg_addr == `SEA_OFS_MSC; // control read
  logic [15:0] presc_q; // prescaler as last written
  logic [1:0] mode_q; // filter mode as last written
  logic [15:0] lo_q; // cycles the clock has been pulled low
  logic [15:0] hi_q; // cycles the clock has been released
  // ----------------------------------------
  // control shadow and clock phase counters
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_q <= `SEA_PRESC_RST;
      mode_q <= `SEA_MODE_RST;
      lo_q <= 16'h0;
      hi_q <= 16'hffff;
    end else begin
      if (reg_wr && reg_addr == `SEA_OFS_MSC) begin
        presc_q <= reg_wdata[15:0];
        mode_q <= reg_wdata[21:20];
      end
      lo_q <= ck ? 16'h0 : lo_q + {15'h0, lo_q != 16'hffff};
      hi_q <= !ck ? 16'h0 : hi_q + {15'h0, hi_q != 16'hffff};
    end
  end
  a_busy_on_start:
    assert property (eac_wr ##1 eac_rd |=> reg_rdata[24])
    else $error("busy not set by a start");
  a_done_cleared:
    assert property (eac_wr ##1 eac_rd |=> !reg_rdata[25])
    else $error("done still set after a start");
  a_busy_done_excl:
    assert property (eac_rd |=> !(reg_rdata[24] && reg_rdata[25]))
    else $error("busy and done both set");
  a_clk_low_min:
    assert property ($rose(ck) |-> lo_q >= presc_q * 2)
    else $error("clock low phase too short");
  a_clk_high_min:
    assert property ($fell(ck) |-> hi_q >= presc_q * 2)
    else $error("clock high phase too short");
  a_clk_stopped:
    assert property (presc_q < 16'h2 |=> $stable(ck))
    else $error("clock moved with prescaler stopped");
  a_presc_back:
    assert property (msc_rd |=> reg_rdata[15:0] == presc_q)
    else $error("prescaler readback wrong");
  a_mode_back:
    assert property (msc_rd |=> reg_rdata[31:16] == {10'h0, mode_q, 4'h0})
    else $error("filter mode readback wrong");
endmodule // sea_checker
bind sea_top sea_checker chk_u (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .master_serial_clock_pin_oe_b(master_serial_clock_pin_oe_b)
);
`default_nettype wire

/* sea_eeprom_model.sv */
// behavioural serial eeprom on the open-drain clock and data lines
`default_nettype none
module sea_eeprom_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic nak,
  input wire logic slow,
  output logic sda_pull,
  output logic scl_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [15:0]]; // sparse byte store
  logic [15:0] ptr; // byte address pointer
  logic [7:0] sh; // current byte
  int n = 9; // bit slot in the nine-bit frame
  int ph = 9; // 0 dev, 1 hi, 2 lo, 3 data in, 4 data out, 9 idle
  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
  end
  realtime t_ck; // last clock edge; data moving with it is hold time
  always @(scl) t_ck = $realtime;
  // start and stop: data moves while the clock is high
  always @(negedge sda) #1 if (scl && t_ck < $realtime - 1) begin
    n = 0;
    ph = 0;
  end
  always @(posedge sda) #1 if (scl && t_ck < $realtime - 1) ph = 9;
  // bits are taken at the rising clock edge
  always @(posedge scl) begin
    if (n < 8 && ph != 4) sh = {sh[6:0], sda};
    if (n == 8 && ph == 4 && sda) ph = 9; // master refuses: stop sending
    n = n + 1;
  end
  // answers change only while the clock is low
  always @(negedge scl) begin
    if (n == 8 && ph != 4) begin
      sda_pull = ph < 4 && (ph > 0 || sh[7:1] == DEV && !nak);
      if (ph == 1) ptr[15:8] = sh;
      if (ph == 2) ptr[7:0] = sh;
      if (ph == 3) mem[ptr] = sh;
      if (ph == 3) ptr = ptr + 16'h1;
      if (ph == 0 && sda_pull) ph = sh[0] ? 4 : 1;
      else if (ph == 1 || ph == 2) ph = ph + 1;
    end else if (n == 8) sda_pull = 1'b0; // leave the slot to the master
    if (n == 9) begin
      n = 0;
      sda_pull = 1'b0;
      if (ph == 4) sh = mem.exists(ptr) ? mem[ptr] : 8'hff;
      if (ph == 4) ptr = ptr + 16'h1;
    end
    if (ph == 4 && n < 8) sda_pull = !sh[7 - n];
  end
  // slow answer: hold the clock low after each byte
  always @(negedge scl) if (slow && n == 8) begin
    scl_pull = 1'b1;
    #400 scl_pull = 1'b0;
  end
endmodule // sea_eeprom_model
`default_nettype wire

/* sea_top_tb.sv */
// self-checking bench for the serial eeprom access port
`default_nettype none
`include "sea_map.vh"
module sea_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, nak = 0, slow = 0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, v;
  wire logic [31:0] reg_rdata;
  wire logic irq, ck_oe_b, ck_o, dt_oe_b, dt_o, sda_pull, scl_pull;
  int fails = 0, checked = 0;
  wire logic scl = (ck_oe_b | ck_o) & !scl_pull; // pulled up when free
  wire logic sda = (dt_oe_b | dt_o) & !sda_pull; // pulled up when free
  sea_top dut_u (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq(irq),
    .master_serial_clock_pin_i(scl),
    .master_serial_clock_pin_o(ck_o),
    .master_serial_clock_pin_oe_b(ck_oe_b),
    .master_serial_data_pin_i(sda),
    .master_serial_data_pin_o(dt_o),
    .master_serial_data_pin_oe_b(dt_oe_b)
  );
  sea_eeprom_model mdl_u (
    .scl(scl),
    .sda(sda),
    .nak(nak),
    .slow(slow),
    .sda_pull(sda_pull),
    .scl_pull(scl_pull)
  );
  initial forever #4 sys_clk = ~sys_clk;
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // register write, then one idle cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // register read into v
  task automatic rd(input logic [11:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask
  // start with done written as one, read back at once
  task automatic start(input logic op, input logic [15:0] a, d);
    reg_wr <= 1'b1;
    reg_addr <= `SEA_OFS_EAC;
    reg_wdata <= {5'h0, op, 2'b10, d[7:0], a};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    rd(`SEA_OFS_EAC);
    check("busy", {30'h0, v[25:24]}, 32'h1);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 8000; i++) begin
      rd(`SEA_OFS_EAC);
      if (v[25] === 1'b1) return;
    end
    fails++;
    test_done;
  endtask
  task automatic t_reset;
    rd(`SEA_OFS_MSC);
    check("msc", v, 32'h53);
    rd(`SEA_OFS_EAC);
    check("eac", v, 32'h0);
  endtask
  task automatic t_write;
    wr(`SEA_OFS_MSC, 32'h0020_0008);
    start(0, 16'hffff, 16'hc3);
    wait_done;
    check("wdat", {24'h0, mdl_u.mem[16'hffff]}, 32'hc3);
    check("addr", {16'h0, v[15:0]}, 32'hffff);
    start(0, 16'h0000, 16'h3c);
    wait_done;
    check("wdat0", {24'h0, mdl_u.mem[16'h0]}, 32'h3c);
  endtask
  task automatic t_read;
    mdl_u.mem[16'h1234] = 8'ha5;
    slow <= 1'b1;
    start(1, 16'h1234, 16'h5a);
    wait_done;
    check("rdat", {24'h0, v[23:16]}, 32'ha5);
    check("op", {31'h0, v[26]}, 32'h1);
    slow <= 1'b0;
  endtask
  // a second start while busy must leave no trace
  task automatic t_busy;
    start(0, 16'h0100, 16'h11);
    start(1, 16'h0200, 16'h22);
    wait_done;
    check("keep", {24'h0, mdl_u.mem[16'h0100]}, 32'h11);
    check("none", mdl_u.mem.exists(16'h0200), 32'h0);
    check("adr1", {16'h0, v[15:0]}, 32'h0100);
  endtask
  // refused device address, interrupt raise, mask and clear
  task automatic t_nack;
    nak <= 1'b1;
    wr(`SEA_OFS_IEN, 32'h2);
    start(0, 16'h0040, 16'h77);
    wait_done;
    check("irq", {31'h0, irq}, 32'h1);
    rd(`SEA_OFS_IST);
    check("ist", v, 32'h3);
    wr(`SEA_OFS_IEN, 32'h0);
    check("mask", {31'h0, irq}, 32'h0);
    wr(`SEA_OFS_ICL, 32'h3);
    rd(`SEA_OFS_IST);
    check("clr", v, 32'h0);
    rd(12'h0cc);
    check("unmap", v, 32'h0);
    nak <= 1'b0;
  endtask
  // prescaler one: clock stands, busy holds
  task automatic t_stop;
    wr(`SEA_OFS_MSC, 32'h0020_0001);
    start(0, 16'h0300, 16'h33);
    repeat (300) @(posedge sys_clk);
    rd(`SEA_OFS_EAC);
    check("hold", {31'h0, v[24]}, 32'h1);
    check("sclq", {31'h0, ck_oe_b}, 32'h1);
    wr(`SEA_OFS_MSC, 32'h0020_0008);
    wait_done;
  endtask
  // start latency in each filter mode
  task automatic t_filter;
    int lat [3];
    nak <= 1'b1;
    for (int m = 2; m >= 0; m--) begin
      wr(`SEA_OFS_MSC, {10'h0, m[1:0], 20'h53});
      reg_wr <= 1'b1;
      reg_addr <= `SEA_OFS_EAC;
      reg_wdata <= 32'h0000_0400;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      lat[m] = 0;
      while (dt_oe_b === 1'b1 && lat[m] < 400) begin
        @(negedge sys_clk);
        lat[m]++;
      end
      @(posedge sys_clk);
      wait_done;
    end
    check("off", lat[2] < 8, 32'h1);
    check("fast", (lat[1] - lat[2]) inside {[8:16]}, 32'h1);
    check("norm", (lat[0] - lat[2]) inside {[120:130]}, 32'h1);
    wr(`SEA_OFS_MSC, 32'h0030_0008);
    rd(`SEA_OFS_MSC);
    check("mode3", v, 32'h0030_0008);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_write;
    t_read;
    t_busy;
    t_nack;
    t_stop;
    t_filter;
    test_done;
  end
endmodule // sea_top_tb
`default_nettype wire
